// file: rtl/flash_unlock_erase_write_ctrl.sv
// Purpose: program flash self-programming controller: key unlock, row
//          erase, holding latch commit, stall, completion and error flags
// Assumes: AXI4-Lite slave, 20 MHz ref_clk; irq_taken, debug_halt and
//          row_protected come from logic on ref_clk
// Notes:   flash array is outside; this block drives it with timed strobes
// Behaviour
// - erase, commit and other array writes need a completed unlock first
// - cpu stalls from accepted start until the operation finishes
// - steps must be consecutive; interrupt or debug halt cancels them
// - self erase unit is one 64-byte row; no word or bulk erase
// - row erase uses pointer bits 21 to 6, ignoring bits 5 to 0
// - erase is a long write ended by the internal programming timer
// - erase on a protected row skips, clears start, sets error
// - erase done clears start, sets done flag, interrupts if enabled
// - erase leaves holding latches and write enable alone
// - an operation cut short by warm reset sets the error flag; power-on reset clears it
// - start with pointer at an invalid address sets the error flag
// - flash is programmed only as a whole block from holding latches
// - latch loads ignore protection, are short, leave done flag alone
// - commit to protected or invalid address is dropped with error
// - commit done clears start, sets done, resets latches to ones
// - latches hold FFh after reset and commit; FFh bytes skip writing
// - target 00 is eeprom, 10 program flash, low bit 1 config space
// - firmware can set the start bit but only hardware clears it
// - the key register has no storage and reads as zero
// - start does nothing unless write enable is set
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module flash_unlock_erase_write_ctrl #(
  parameter int PROG_CYCLES  = (`FC_PROG_TIME_NS + `FC_CLK_PERIOD_NS - 1)
                               / `FC_CLK_PERIOD_NS,
  parameter int ERASE_CYCLES = (`FC_ERASE_TIME_NS + `FC_CLK_PERIOD_NS - 1)
                               / `FC_CLK_PERIOD_NS,
  parameter int LATCH_AW     = `FC_LATCH_AW,
  parameter int PFM_BYTES    = `FC_PFM_BYTES,
  parameter int EE_BYTES     = `FC_EE_BYTES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  por_n,
  input  wire logic [`FC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`FC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  irq_taken,
  input  wire logic                  debug_halt,
  input  wire logic                  row_protected,
  output logic                       cpu_stall,
  output logic                       nvm_irq,
  output logic                       array_erase,
  output logic                       array_wr,
  output logic [`FC_PTR_W-1:0]       array_addr,
  output logic [7:0]                 array_wdata,
  output flash_ctrl_pkg::target_t    array_target
);
  import flash_ctrl_pkg::*;

  localparam int TMR_W = $clog2(PROG_CYCLES + ERASE_CYCLES + 1) + 1;

  function automatic logic [`FC_ADDR_W-1:0] word_of(
    input logic [`FC_ADDR_W-1:0] a);
    return {a[`FC_ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic reg_hit(input logic [`FC_ADDR_W-1:0] a);
    logic [`FC_ADDR_W-1:0] w;
    w = word_of(a);
    return (w == `FC_ADDR_CTRL) || (w == `FC_ADDR_KEY) ||
           (w == `FC_ADDR_PTR)  || (w == `FC_ADDR_LATCH) ||
           (w == `FC_ADDR_TWR)  || (w == `FC_ADDR_STAT);
  endfunction

  function automatic logic addr_valid(input target_t t,
                                      input logic [`FC_PTR_W-1:0] p);
    if (t[`FC_TGT_CFG_BIT]) begin
      return p[`FC_PTR_SPACE_BIT];
    end else if (t == `FC_TGT_PFM) begin
      return !p[`FC_PTR_SPACE_BIT] && (32'(p) < PFM_BYTES);
    end else if (t == `FC_TGT_EE) begin
      return 32'(p) < EE_BYTES;
    end
    return 1'b0;
  endfunction

  // bus state
  logic [`FC_ADDR_W-1:0] aw_addr;
  logic [`FC_ADDR_W-1:0] ar_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  wr_go;
  logic                  rd_go;
  logic                  lane0;

  // registers and engine state
  target_t               target;
  logic                  erase_sel;
  logic                  write_enable_bit;
  logic                  busy;
  logic [`FC_PTR_W-1:0]  table_pointer;
  logic [7:0]            table_latch;
  logic                  nvm_done_flag;
  logic                  nvm_done_irq_enable;
  logic                  write_error_flag;
  logic                  inflight;
  logic                  started;
  unlock_state_t         unl;
  logic [`FC_GAP_W-1:0]  gap_cnt;
  op_state_t             op;
  logic [TMR_W-1:0]      timer;
  logic [LATCH_AW-1:0]   scan_idx;
  logic                  scan_issue;
  logic [LATCH_AW-1:0]   idx_d;
  logic                  data_valid;
  logic [7:0]            latch_rd;
  logic                  latch_clear;

  logic                  wr_ctrl;
  logic                  wr_key;
  logic                  wr_ptr;
  logic                  wr_latch;
  logic                  wr_twr;
  logic                  wr_stat;
  logic                  start_ok;
  logic                  start_bad;
  logic                  launch;
  logic                  reject;
  logic                  op_done;
  target_t               new_target;

  assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_go  = !s_axi_arready && !s_axi_rvalid;
  assign lane0  = w_strb[0];
  assign wr_ctrl  = wr_go && lane0 && word_of(aw_addr) == `FC_ADDR_CTRL;
  assign wr_key   = wr_go && lane0 && word_of(aw_addr) == `FC_ADDR_KEY;
  assign wr_ptr   = wr_go && word_of(aw_addr) == `FC_ADDR_PTR;
  assign wr_latch = wr_go && lane0 && word_of(aw_addr) == `FC_ADDR_LATCH;
  assign wr_twr   = wr_go && lane0 && word_of(aw_addr) == `FC_ADDR_TWR;
  assign wr_stat  = wr_go && lane0 && word_of(aw_addr) == `FC_ADDR_STAT;
  assign new_target = w_data[`FC_TGT_HI:`FC_TGT_LO];

  // start counts only straight after the second key, with write enable
  // taken from the same write so one read-modify-write sets both
  assign start_ok = wr_ctrl && w_data[`FC_BIT_START]
                    && unl == UNL_ARMED
                    && w_data[`FC_BIT_WRITE_ENABLE_BIT]
                    && !busy && !irq_taken && !debug_halt;
  assign start_bad = !addr_valid(new_target, table_pointer)
                     || (new_target == `FC_TGT_PFM && row_protected);
  assign launch  = start_ok && !start_bad;
  assign reject  = start_ok && start_bad;
  assign op_done = (op == OP_ERASE || op == OP_WAIT) && timer == TMR_W'(1);

  // write address and data channels, taken in either order
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FC_RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(aw_addr) ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel; the key register answers zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FC_RESP_OKAY;
      ar_addr       <= '0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr       <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= reg_hit(ar_addr) ? `FC_RESP_OKAY : `FC_RESP_SLVERR;
        s_axi_rdata  <= '0;
        unique case (word_of(ar_addr))
          `FC_ADDR_CTRL: begin
            s_axi_rdata[`FC_TGT_HI:`FC_TGT_LO] <= target;
            s_axi_rdata[`FC_BIT_ERASE] <= erase_sel;
            s_axi_rdata[`FC_BIT_WRITE_ENABLE_BIT]  <= write_enable_bit;
            s_axi_rdata[`FC_BIT_START] <= busy;
          end
          `FC_ADDR_PTR:   s_axi_rdata[`FC_PTR_W-1:0] <= table_pointer;
          `FC_ADDR_LATCH: s_axi_rdata[7:0] <= table_latch;
          `FC_ADDR_STAT: begin
            s_axi_rdata[`FC_BIT_ERR]  <= write_error_flag;
            s_axi_rdata[`FC_BIT_DONE] <= nvm_done_flag;
            s_axi_rdata[`FC_BIT_IEN]  <= nvm_done_irq_enable;
          end
          default: s_axi_rdata <= '0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // control fields; the start bit lives in busy and software cannot clear it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      target           <= `FC_TGT_EE;
      erase_sel        <= 1'b0;
      write_enable_bit <= 1'b0;
    end else if (wr_ctrl) begin
      target           <= new_target;
      erase_sel        <= w_data[`FC_BIT_ERASE];
      write_enable_bit <= w_data[`FC_BIT_WRITE_ENABLE_BIT];
    end
  end

  // table pointer and latch; a table write may post-increment bits 20:0
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      table_pointer <= '0;
      table_latch   <= '0;
    end else begin
      if (wr_latch) begin
        table_latch <= w_data[7:0];
      end
      if (wr_ptr) begin
        // per-bit copy so the top byte keeps only the bits that exist
        for (int i = 0; i < `FC_PTR_W; i++) begin
          if (w_strb[i / 8]) begin
            table_pointer[i] <= w_data[i];
          end
        end
      end else if (wr_twr && !busy && w_data[`FC_BIT_INC]) begin
        table_pointer[`FC_PTR_SPACE_BIT-1:0] <=
          table_pointer[`FC_PTR_SPACE_BIT-1:0] + 1'b1;
      end
    end
  end

  // unlock tracker: 55h, AAh, start, each within the step window
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      unl     <= UNL_IDLE;
      gap_cnt <= '0;
    end else if (irq_taken || debug_halt) begin
      unl     <= UNL_IDLE;
      gap_cnt <= '0;
    end else if (wr_go) begin
      gap_cnt <= '0;
      if (wr_key && w_data[7:0] == `FC_KEY1 && unl == UNL_IDLE) begin
        unl <= UNL_KEY1;
      end else if (wr_key && w_data[7:0] == `FC_KEY2 && unl == UNL_KEY1) begin
        unl <= UNL_ARMED;
      end else begin
        unl <= UNL_IDLE;
      end
    end else if (unl != UNL_IDLE) begin
      if (gap_cnt == `FC_KEY_GAP) begin
        unl     <= UNL_IDLE;
        gap_cnt <= '0;
      end else begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end

  // operation engine; erase only for program flash with erase selected
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op           <= OP_IDLE;
      busy         <= 1'b0;
      timer        <= '0;
      array_target <= `FC_TGT_EE;
    end else begin
      unique case (op)
        OP_IDLE: begin
          if (launch) begin
            busy         <= 1'b1;
            array_target <= new_target;
            if (new_target == `FC_TGT_PFM && w_data[`FC_BIT_ERASE]) begin
              op    <= OP_ERASE;
              timer <= TMR_W'(ERASE_CYCLES);
            end else begin
              op <= OP_SCAN;
            end
          end
        end
        OP_ERASE, OP_WAIT: begin
          if (op_done) begin
            op   <= OP_IDLE;
            busy <= 1'b0;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        OP_SCAN: begin
          if (data_valid && idx_d == '1) begin
            op    <= OP_WAIT;
            timer <= TMR_W'(PROG_CYCLES);
          end
        end
      endcase
    end
  end

  assign latch_clear = op_done && op == OP_WAIT;

  // latch walk: every holding byte is read in order, one a cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_idx   <= '0;
      scan_issue <= 1'b0;
      idx_d      <= '0;
      data_valid <= 1'b0;
    end else begin
      idx_d      <= scan_idx;
      data_valid <= scan_issue;
      if (launch) begin
        scan_idx   <= '0;
        scan_issue <= !(new_target == `FC_TGT_PFM && w_data[`FC_BIT_ERASE]);
      end else if (scan_issue) begin
        scan_idx   <= scan_idx + 1'b1;
        scan_issue <= scan_idx != '1;
      end
    end
  end

  holding_latch_mem #(
    .ADDR_W (LATCH_AW)
  ) u_latches (
    .clk       (ref_clk),
    .arst_n    (arst_n),
    .clear_all (latch_clear),
    .wr_en     (wr_twr && !busy),
    .wr_addr   (table_pointer[LATCH_AW-1:0]),
    .wr_data   (table_latch),
    .rd_addr   (scan_idx),
    .rd_data   (latch_rd)
  );

  // array strobes; erased-value bytes are skipped so the cell keeps its data
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      array_erase <= 1'b0;
      array_wr    <= 1'b0;
      array_addr  <= '0;
      array_wdata <= `FC_BYTE_ERASED;
    end else begin
      array_erase <= launch && new_target == `FC_TGT_PFM
                     && w_data[`FC_BIT_ERASE];
      array_wr    <= data_valid && latch_rd != `FC_BYTE_ERASED;
      if (launch) begin
        array_addr <= {table_pointer[`FC_PTR_W-1:`FC_ROW_LSB],
                       {`FC_ROW_LSB{1'b0}}};
      end else if (data_valid) begin
        array_addr  <= {table_pointer[`FC_PTR_W-1:LATCH_AW], idx_d};
        array_wdata <= latch_rd;
      end
    end
  end

  // done flag: hardware set wins over a same-cycle write-one-to-clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_done_flag       <= 1'b0;
      nvm_done_irq_enable <= 1'b0;
      nvm_irq             <= 1'b0;
      cpu_stall           <= 1'b0;
      started             <= 1'b0;
    end else begin
      started   <= 1'b1;
      cpu_stall <= launch || (busy && !op_done);
      if (op_done) begin
        nvm_done_flag <= 1'b1;
      end else if (wr_stat && w_data[`FC_BIT_DONE]) begin
        nvm_done_flag <= 1'b0;
      end
      if (wr_stat) begin
        nvm_done_irq_enable <= w_data[`FC_BIT_IEN];
      end
      nvm_irq <= nvm_done_flag && nvm_done_irq_enable;
    end
  end

  // error flag and in-flight marker survive a warm reset so that an
  // operation cut short by it is reported once the reset lets go
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      write_error_flag <= 1'b0;
      inflight         <= 1'b0;
    end else begin
      if (launch) begin
        inflight <= 1'b1;
      end else if (op_done || !started) begin
        inflight <= 1'b0;
      end
      if (reject || (!started && inflight)) begin
        write_error_flag <= 1'b1;
      end else if (op_done || (wr_stat && w_data[`FC_BIT_ERR])) begin
        write_error_flag <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/holding_latch_mem.sv
// Purpose: byte-wide holding latch block with one-cycle bulk reset to FFh
// Assumes: one write and one read port on the same clock
// Notes:   a written-flag per byte stands in for resetting the storage, so
//          the data array itself needs no reset and maps to plain RAM
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module holding_latch_mem #(
  parameter int ADDR_W = `FC_LATCH_AW
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clear_all,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);
  logic [7:0]           store [2**ADDR_W];
  logic [2**ADDR_W-1:0] written;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      written <= '0;
    end else if (clear_all) begin
      written <= '0;
    end else if (wr_en) begin
      written[wr_addr] <= 1'b1;
    end
  end

  // unwritten bytes read as erased, so reset and commit both leave FFh
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= `FC_BYTE_ERASED;
    end else begin
      rd_data <= written[rd_addr] ? store[rd_addr] : `FC_BYTE_ERASED;
    end
  end
endmodule

// file: shared/flash_ctrl_map.svh
// Purpose: register offsets, field positions, reset values and timing
//          figures of the flash self-programming controller
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte address
// Notes:   definitions only
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// register byte offsets
`define FC_ADDR_CTRL      8'h00
`define FC_ADDR_KEY       8'h04
`define FC_ADDR_PTR       8'h08
`define FC_ADDR_LATCH     8'h0c
`define FC_ADDR_TWR       8'h10
`define FC_ADDR_STAT      8'h14
`define FC_ADDR_W         8

// control register fields
`define FC_TGT_HI         1
`define FC_TGT_LO         0
`define FC_BIT_ERASE      2
`define FC_BIT_WRITE_ENABLE_BIT       3
`define FC_BIT_START      4
// status register fields
`define FC_BIT_ERR        0
`define FC_BIT_DONE       1
`define FC_BIT_IEN        2
// table write register field
`define FC_BIT_INC        0

// memory target encodings
`define FC_TGT_EE         2'b00
`define FC_TGT_PFM        2'b10
`define FC_TGT_CFG_BIT    0

// unlock keys
`define FC_KEY1           8'h55
`define FC_KEY2           8'haa

// pointer layout
`define FC_PTR_W          22
`define FC_PTR_SPACE_BIT  21
`define FC_ROW_LSB        6
`define FC_LATCH_AW       7
`define FC_PFM_BYTES      65536
`define FC_EE_BYTES       1024

// holding latch erased value
`define FC_BYTE_ERASED    8'hff

// bus answers
`define FC_RESP_OKAY      2'b00
`define FC_RESP_SLVERR    2'b10

// timing
`define FC_CLK_PERIOD_NS  50
`define FC_PROG_TIME_NS   2000000
`define FC_ERASE_TIME_NS  2000000
`define FC_KEY_GAP        4'h8
`define FC_GAP_W          4

`endif

// file: shared/flash_ctrl_pkg.sv
// Purpose: types shared by the flash self-programming controller
// Assumes: nothing beyond the map header
// Notes:   encodings are left to the tools
package flash_ctrl_pkg;

  typedef logic [1:0] target_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_SCAN,
    OP_WAIT
  } op_state_t;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_KEY1,
    UNL_ARMED
  } unlock_state_t;

endpackage

// file: tb/core_side_model.sv
// Purpose: core side of the controller: interrupt, halt, protection
// Assumes: driven by bench calls
// Notes:   counts array strobes so the bench can judge them
`timescale 1ns/1ns
module core_side_model (
  input wire logic        ref_clk,
  input wire logic        cpu_stall,
  input wire logic        array_erase,
  input wire logic        array_wr,
  input wire logic [21:0] array_addr,
  input wire logic [7:0]  array_wdata,
  output logic            irq_taken,
  output logic            debug_halt,
  output logic            row_protected
);
  int         n_erase = 0, n_wr = 0, n_stall = 0;
  logic [21:0] last_addr = 22'h0;
  logic [7:0]  last_data = 8'h0;
  // interrupts stay masked unless a test asks for one
  initial begin
    irq_taken = 1'b0;
    debug_halt = 1'b0;
    row_protected = 1'b0;
  end
  always @(posedge ref_clk) begin
    n_stall <= n_stall + int'(cpu_stall);
    if (array_erase || array_wr) begin
      last_addr <= array_addr;
      last_data <= array_wdata;
    end
    n_erase <= n_erase + int'(array_erase);
    n_wr <= n_wr + int'(array_wr);
  end
  task automatic protect(input bit on);
    row_protected <= on;
  endtask
  task automatic pulse(input bit halt);
    @(posedge ref_clk);
    if (halt) debug_halt <= 1'b1;
    else irq_taken <= 1'b1;
    @(posedge ref_clk);
    debug_halt <= 1'b0;
    irq_taken <= 1'b0;
  endtask
endmodule

// file: tb/flash_ctrl_props.sv
// Purpose: port-level checks of the flash self-programming controller
// Assumes: bench sets ERASE_CYCLES of at least 8
// Notes:   bound from the bench top
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module flash_ctrl_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        cpu_stall,
  input wire logic        array_erase,
  input wire logic        array_wr,
  input wire logic [21:0] array_addr,
  input wire logic [7:0]  array_wdata,
  input wire logic [1:0]  array_target
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_KEY_READ_ZERO: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `FC_ADDR_KEY
    |-> ##[1:2] (s_axi_rvalid && s_axi_rdata == 32'h0))
    else $error("key register read not zero");
  AST_ERASE_ROW_BASE: assert property (
    array_erase |-> array_addr[5:0] == 6'h0)
    else $error("erase address not a row base");
  AST_SKIP_ERASED: assert property (
    array_wr |-> array_wdata != 8'hff) else $error("erased byte written");
  AST_ARRAY_IN_STALL: assert property (
    array_erase || array_wr |-> cpu_stall) else $error("array op unstalled");
  AST_ERASE_LONG: assert property (
    array_erase |-> cpu_stall [*8]) else $error("erase stall too short");
  AST_STALL_FROM_WRITE: assert property (
    $rose(cpu_stall) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
    || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4))
    else $error("stall without a bus write");
  AST_ERASE_ONCE: assert property (
    array_erase |=> !array_erase) else $error("more than one row erased");
  AST_ERASE_PFM: assert property (
    array_erase |-> array_target == `FC_TGT_PFM) else $error("erase target");
endmodule

// file: tb/flash_unlock_erase_write_ctrl_tb_top.sv
// Purpose: register-level tests of the flash self-programming controller
// Assumes: short programming and erase counts
// Notes:   keys go back to back to stay inside the step window
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module flash_unlock_erase_write_ctrl_tb_top;
  logic ref_clk = 0, arst_n = 0, por_n = 0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall, nvm_irq;
  logic irq_taken, debug_halt, row_protected, array_erase, array_wr;
  logic [1:0] s_axi_bresp, s_axi_rresp, array_target;
  logic [21:0] array_addr;
  logic [7:0] array_wdata;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  flash_unlock_erase_write_ctrl #(.PROG_CYCLES(20), .ERASE_CYCLES(10)) dut_u (
    .ref_clk, .arst_n, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_taken, .debug_halt, .row_protected, .cpu_stall, .nvm_irq,
    .array_erase, .array_wr, .array_addr, .array_wdata, .array_target);
  core_side_model m (.ref_clk, .cpu_stall, .array_erase, .array_wr,
    .array_addr, .array_wdata, .irq_taken, .debug_halt, .row_protected);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
  task automatic run(input logic [31:0] c, input logic [31:0] st);
    wr(`FC_ADDR_KEY, 32'h55);
    wr(`FC_ADDR_KEY, 32'haa);
    wr(`FC_ADDR_CTRL, c);
    do rd(`FC_ADDR_STAT, r); while (r[1:0] == 2'b00);
    chk(r, st);
    chk(32'(nvm_irq), 32'(st[1]));
    wr(`FC_ADDR_STAT, 32'h7);
    $display("test with control %h ended", c);
  endtask
  task automatic stop_test();
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1;
    por_n <= 1;
    rd(`FC_ADDR_KEY, r);
    chk(r, 32'h0);
    wr(`FC_ADDR_STAT, 32'h4);
    wr(`FC_ADDR_PTR, 32'h145);
    wr(`FC_ADDR_LATCH, 32'h3c);
    wr(`FC_ADDR_TWR, 32'h1);
    run(32'h1a, 32'h6);
    chk(32'(m.n_wr), 32'h1);
    chk(32'(m.last_addr), 32'h145);
    chk(32'(m.last_data), 32'h3c);
    chk(32'(m.n_stall > 20), 32'h1);
    run(32'h1a, 32'h6);
    chk(32'(m.n_wr), 32'h1);
    run(32'h1e, 32'h6);
    chk(32'(m.n_erase), 32'h1);
    chk(32'(m.last_addr), 32'h140);
    rd(`FC_ADDR_CTRL, r);
    chk(r, 32'he);
    m.protect(1);
    run(32'h1e, 32'h5);
    chk(32'(m.n_erase), 32'h1);
    m.protect(0);
    wr(`FC_ADDR_PTR, 32'h10000);
    run(32'h1a, 32'h5);
    chk(32'(m.n_wr), 32'h1);
    wr(`FC_ADDR_PTR, 32'h145);
    for (int k = 0; k < 4; k++) begin
      wr(`FC_ADDR_KEY, 32'h55);
      if (k == 0) wr(`FC_ADDR_KEY, 32'h11);
      if (k == 1 || k == 2) m.pulse(k == 2);
      wr(`FC_ADDR_KEY, 32'haa);
      wr(`FC_ADDR_CTRL, (k == 3) ? 32'h16 : 32'h1e);
      repeat (20) @(posedge ref_clk);
      rd(`FC_ADDR_STAT, r);
      chk(r, 32'h4);
      chk(32'(m.n_erase), 32'h1);
      $display("refused start %0d ended", k);
    end
    wr(`FC_ADDR_KEY, 32'h55);
    wr(`FC_ADDR_KEY, 32'haa);
    wr(`FC_ADDR_CTRL, 32'h1e);
    repeat (4) @(posedge ref_clk);
    arst_n <= 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1;
    rd(`FC_ADDR_STAT, r);
    chk(r, 32'h1);
    $display("reset during erase ended");
    stop_test();
  end
endmodule
bind flash_unlock_erase_write_ctrl flash_ctrl_props props_u (.ref_clk,
  .arst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_wvalid, .cpu_stall, .array_erase, .array_wr,
  .array_addr, .array_wdata, .array_target);
